// ### hdl/cri_defs.vh
`ifndef CRI_DEFS_VH
`define CRI_DEFS_VH
// axi register byte offsets
`define CRI_A_PSW 4'h0
`define CRI_A_CTL 4'h4
`define CRI_A_STAT 4'h8
`define CRI_RESP_OK 2'h0
`define CRI_RESP_ERR 2'h2
// instruction opcodes on the request port
`define CRI_OP_LCTL 2'h0
`define CRI_OP_STCTL 2'h1
`define CRI_OP_SSM 2'h2
`define CRI_OP_NOP 2'h3
// status word bit positions, bit 0 is the msb
`define CRI_PSW_DAT 5
`define CRI_PSW_IO 6
`define CRI_PSW_EXT 7
`define CRI_PSW_MODE 12
`define CRI_PSW_PROB 15
`define CRI_PSW_RST 16'h0000
// interruption classes
`define CRI_CL_PROG 2'h0
`define CRI_CL_EXT 2'h1
`define CRI_CL_IO 2'h2
`define CRI_CL_NONE 2'h3
// program check codes
`define CRI_PC_PRIV 16'h0002
`define CRI_PC_SPECOP 16'h0013
// external codes, index 0 signals, 1 interval, 2 cpu timer, 3 comparator, 4 console
`define CRI_EC_SIG 16'h0100
`define CRI_EC_ITMR 16'h0080
`define CRI_EC_CPUT 16'h1005
`define CRI_EC_CKC 16'h1004
`define CRI_EC_CONS 16'h0040
// extended-mode fixed store words above 127
`define CRI_LOC_EXT 12'h084
`define CRI_LOC_SVC 12'h088
`define CRI_LOC_PROG 12'h08C
`define CRI_ILC_SHIFT 16
`define CRI_NCR 16
`endif

// ### hdl/cri_unit.v
`timescale 1ns/1ns
`include "cri_defs.vh"
// Contract
// - sixteen control registers, numbered zero to fifteen
// - control register access only in supervisor state
// - load writes register, store reads it out
// - every control register thirty-two bits wide
// - unassigned control bits have no effect
// - status bit twelve selects basic/extended mode
// - interruptions taken only at instruction boundaries
// - register zero holds five external subclass masks
// - external mask off blocks all external
// - external taken only with subclass mask set
// - trap bit set: system mask instruction faults
// - trap bit clear: instruction updates system mask
// - extended status word drops channel masks, codes; only psw_out does, the bus readback of the status word keeps bits 0-3
// - extended mode channel masks in register two
// - extended mode external and program codes written above address 127
// - status bit five enables translation, full mode; extended mode only
// - extended channel n needs bit six and mask
// - basic mode channels gated by status bits 0-3
module cri_unit #(
  parameter P_SSM_TRAP = 1, // trap bit in register zero
  parameter P_SUB_SIG = 26, // external signals 2-7
  parameter P_SUB_ITMR = 24, // interval timer
  parameter P_SUB_CPUT = 21, // processor timer
  parameter P_SUB_CKC = 20, // clock comparator
  parameter P_SUB_CONS = 25 // operator console
) (
  input wire aclk, // processor clock
  input wire aresetn, // sync reset, low
  input wire [3:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // byte enables
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // response accepted
  input wire [3:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read accepted
  input wire instr_valid, // instruction pulse
  input wire [1:0] instr_op, // instruction opcode
  input wire [3:0] instr_reg, // control register number
  input wire [31:0] instr_data, // load operand or new mask
  input wire [1:0] instr_ilc, // instruction length code
  output reg instr_done, // completion pulse
  output reg [31:0] instr_rdata, // stored register value
  input wire insn_boundary, // boundary pulse from sequencer
  input wire [4:0] ext_req, // external requests, async
  input wire [3:0] chan_req, // channel requests, async
  output reg intr_take, // interruption taken pulse
  output reg [1:0] intr_class, // class of taken interruption
  output reg [15:0] intr_code, // code of taken interruption
  output reg [1:0] intr_ilc, // length code of taken one
  output reg low_wr, // fixed store write pulse
  output reg [11:0] low_addr, // fixed store byte address
  output reg [31:0] low_data, // ilc and code word
  output reg [0:15] psw_out, // status word high half
  output reg ec_mode, // extended control mode
  output reg dat_enable // translation enabled
);
  // control register file in local storage
  reg [0:31] cr_q [0:`CRI_NCR-1];
  reg [0:15] psw_q; // status word high half
  reg rmode_q; // restricted translation mode
  reg pc_pend_q; // program check pending
  reg [15:0] pc_code_q; // its code
  reg [1:0] pc_ilc_q; // its length code
  reg [1:0] last_cl_q; // last class taken
  reg [15:0] last_code_q; // last code taken
  reg [8:0] s1_q, s2_q, s3_q, req_q; // input synchroniser
  integer i; // synchroniser bit index
  integer j; // register-file reset index
  // arbitration result, combinational
  reg intr_take_d; // take at this boundary
  reg [1:0] cl_d; // class chosen
  reg [15:0] code_d; // code chosen
  reg [1:0] ilc_d; // length code chosen

  // extended mode bit, never a character code
  wire ec = psw_q[`CRI_PSW_MODE];
  // supervisor state while the problem bit is clear
  wire sup = ~psw_q[`CRI_PSW_PROB];
  // only registers zero and two steer anything here
  wire [0:31] cr0 = cr_q[0];
  wire [0:31] cr2 = cr_q[2];

  // subclass masks picked from register zero; other bits ignored except the trap bit
  wire [4:0] sub_m = {cr0[P_SUB_CONS], cr0[P_SUB_CKC], cr0[P_SUB_CPUT],
    cr0[P_SUB_ITMR], cr0[P_SUB_SIG]};
  wire [4:0] ext_ok = req_q[4:0] & sub_m &
    {5{psw_q[`CRI_PSW_EXT]}};

  // channel gating depends on mode
  wire [3:0] ch_ec = {cr2[3], cr2[2], cr2[1], cr2[0]} &
    {4{psw_q[`CRI_PSW_IO]}};
  wire [3:0] ch_bc = {psw_q[3], psw_q[2], psw_q[1], psw_q[0]};
  wire [3:0] ch_ok = req_q[8:5] & (ec ? ch_ec : ch_bc);

  // lowest set bit, shared by both priority scans
  function [2:0] first_bit;
    input [4:0] v;
    begin
      first_bit = v[0] ? 3'h0 : v[1] ? 3'h1 : v[2] ? 3'h2 : v[3] ? 3'h3 : 3'h4;
    end
  endfunction

  // external code per subclass index
  function [15:0] ext_code;
    input [2:0] n;
    begin
      case (n)
        3'h0: ext_code = `CRI_EC_SIG;
        3'h1: ext_code = `CRI_EC_ITMR;
        3'h2: ext_code = `CRI_EC_CPUT;
        3'h3: ext_code = `CRI_EC_CKC;
        default: ext_code = `CRI_EC_CONS;
      endcase
    end
  endfunction

  wire [2:0] ext_n = first_bit(ext_ok);
  wire [2:0] ch_n = first_bit({1'b0, ch_ok});

  // pins: three flops, accept when second and third agree
  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 9'h000;
      s2_q <= 9'h000;
      s3_q <= 9'h000;
      req_q <= 9'h000;
    end else begin
      s1_q <= {chan_req, ext_req};
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a glitch seen by one flop only never reaches the arbiter
      for (i = 0; i < 9; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          req_q[i] <= s3_q[i];
        end
      end
    end
  end

  // axi handshake conditions
  // the ready guards stop a second take while the master still holds valid
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;
  wire is_ssm = instr_valid & (instr_op == `CRI_OP_SSM);
  // every opcode but nop is privileged
  wire priv = instr_valid & (instr_op != `CRI_OP_NOP);
  // trap bit only matters for the set-mask opcode
  wire trap = is_ssm & cr0[P_SSM_TRAP];

  // instruction execution and status word
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (j = 0; j < `CRI_NCR; j = j + 1) begin
        cr_q[j] <= 32'h00000000;
      end
      psw_q <= `CRI_PSW_RST;
      rmode_q <= 1'b0;
      pc_pend_q <= 1'b0;
      pc_code_q <= 16'h0000;
      pc_ilc_q <= 2'h0;
      instr_done <= 1'b0;
      instr_rdata <= 32'h00000000;
    end else begin
      // every instruction completes next cycle, refused ones too
      instr_done <= instr_valid;
      // bus write is dropped while a set-mask instruction is presented, refused or not
      if (wr_go && !is_ssm) begin
        if (s_axi_awaddr == `CRI_A_PSW) begin
          if (s_axi_wstrb[0]) psw_q[8:15] <= s_axi_wdata[7:0];
          if (s_axi_wstrb[1]) psw_q[0:7] <= s_axi_wdata[15:8];
        end else if (s_axi_awaddr == `CRI_A_CTL && s_axi_wstrb[0]) begin
          rmode_q <= s_axi_wdata[0];
        end
      end
      // a new fault sets; the take below clears only when none arrives
      if (intr_take_d && cl_d == `CRI_CL_PROG) begin
        pc_pend_q <= 1'b0;
      end
      if (priv && !sup) begin
        // problem state: nothing changes, nothing leaks
        pc_pend_q <= 1'b1;
        pc_code_q <= `CRI_PC_PRIV;
        pc_ilc_q <= instr_ilc;
        instr_rdata <= 32'h00000000;
      end else if (trap) begin
        // fault instead, system mask left alone
        pc_pend_q <= 1'b1;
        pc_code_q <= `CRI_PC_SPECOP;
        pc_ilc_q <= instr_ilc;
      end else if (is_ssm) begin
        psw_q[0:7] <= instr_data[7:0];
      end else if (instr_valid && instr_op == `CRI_OP_LCTL) begin
        cr_q[instr_reg] <= instr_data;
      end else if (instr_valid && instr_op == `CRI_OP_STCTL) begin
        instr_rdata <= cr_q[instr_reg];
      end
    end
  end

  // boundary arbitration: program, external, then channels
  always @* begin
    intr_take_d = 1'b0;
    cl_d = `CRI_CL_NONE;
    code_d = 16'h0000;
    ilc_d = 2'h0;
    // never mid-instruction, so the saved state is exact
    if (insn_boundary && !instr_valid) begin
      intr_take_d = 1'b1;
      // faults first: they belong to the instruction just ended
      if (pc_pend_q) begin
        cl_d = `CRI_CL_PROG;
        code_d = pc_code_q;
        ilc_d = pc_ilc_q;
      end else if (|ext_ok) begin
        cl_d = `CRI_CL_EXT;
        code_d = ext_code(ext_n);
      end else if (|ch_ok) begin
        cl_d = `CRI_CL_IO;
        code_d = {13'h0000, ch_n};
      end else begin
        intr_take_d = 1'b0;
      end
    end
  end

  // taken interruption and fixed store report
  always @(posedge aclk) begin
    if (!aresetn) begin
      intr_take <= 1'b0;
      intr_class <= `CRI_CL_NONE;
      intr_code <= 16'h0000;
      intr_ilc <= 2'h0;
      low_wr <= 1'b0;
      low_addr <= 12'h000;
      low_data <= 32'h00000000;
      last_cl_q <= `CRI_CL_NONE;
      last_code_q <= 16'h0000;
    end else begin
      intr_take <= intr_take_d;
      low_wr <= 1'b0;
      if (intr_take_d) begin
        intr_class <= cl_d;
        intr_code <= code_d;
        intr_ilc <= ilc_d;
        // kept for the status register readback
        last_cl_q <= cl_d;
        last_code_q <= code_d;
        // extended mode: external and program codes go to storage, not the status word
        if (ec && cl_d != `CRI_CL_IO) begin
          low_wr <= 1'b1;
          low_addr <= (cl_d == `CRI_CL_EXT) ? `CRI_LOC_EXT : `CRI_LOC_PROG;
          low_data <= {14'h0000, ilc_d, code_d};
        end
      end
    end
  end

  // status word view and translation enable
  always @(posedge aclk) begin
    if (!aresetn) begin
      psw_out <= `CRI_PSW_RST;
      ec_mode <= 1'b0;
      dat_enable <= 1'b0;
    end else begin
      // one cycle behind the live word, like every output
      psw_out <= psw_q;
      // extended format carries no channel masks in bits 0-3
      if (ec) psw_out[0:3] <= 4'h0;
      ec_mode <= ec;
      // restricted mode ignores bit five; software must keep it clear
      dat_enable <= ec & psw_q[`CRI_PSW_DAT] & ~rmode_q;
    end
  end

  // axi write channel: both beats taken together, then response
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CRI_RESP_OK;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready <= wr_go;
      // response code decided when the beats are taken
      if (wr_go) begin
        s_axi_bresp <= (s_axi_awaddr == `CRI_A_PSW || s_axi_awaddr == `CRI_A_CTL ||
          s_axi_awaddr == `CRI_A_STAT) ? `CRI_RESP_OK : `CRI_RESP_ERR;
      end
      // response raised at the ready edge, so it follows both handshakes
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel; control registers are not visible here
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CRI_RESP_OK;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rresp <= `CRI_RESP_OK;
        case (s_axi_araddr)
          `CRI_A_PSW: s_axi_rdata <= {16'h0000, psw_q};
          `CRI_A_CTL: s_axi_rdata <= {31'h00000000, rmode_q};
          `CRI_A_STAT: s_axi_rdata <= {8'h00, pc_pend_q, dat_enable, ec_mode,
            3'h0, last_cl_q, last_code_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `CRI_RESP_ERR;
          end
        endcase
      end
      // data valid only after the address handshake edge
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // cri_unit

// ### sim/cri_unit_chk.sv
`timescale 1ns/1ns
`include "cri_defs.vh"
module cri_unit_chk (
  input logic aclk, // clock
  input logic aresetn, // sync reset, low
  input logic instr_valid, // instruction strobe
  input logic instr_done, // completion pulse
  input logic insn_boundary, // boundary pulse
  input logic intr_take, // take pulse
  input logic [1:0] intr_class, // taken class
  input logic [15:0] intr_code, // taken code
  input logic low_wr, // fixed store write
  input logic [0:15] psw_out, // status word high half
  input logic ec_mode, // extended mode
  input logic dat_enable // translation on
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_done; instr_valid |=> instr_done; endproperty
  a_done: assert property (p_done) else $error("instruction not completed");
  // takes only at a boundary with no instruction in flight
  property p_take; intr_take |-> $past(insn_boundary) && !$past(instr_valid); endproperty
  a_take: assert property (p_take) else $error("take off a boundary");
  property p_mode; ec_mode == psw_out[12]; endproperty
  a_mode: assert property (p_mode) else $error("mode flag differs from status bit");
  property p_dat; dat_enable |-> ec_mode && psw_out[5]; endproperty
  a_dat: assert property (p_dat) else $error("translation on without its enables");
  property p_ecfmt; ec_mode |-> psw_out[0:3] == 4'h0; endproperty
  a_ecfmt: assert property (p_ecfmt) else $error("channel masks shown in extended mode");
  property p_low; low_wr |-> intr_take && ec_mode && intr_class != `CRI_CL_IO; endproperty
  a_low: assert property (p_low) else $error("fixed store write out of place");
  property p_ext; intr_take && intr_class == `CRI_CL_EXT |-> $past(psw_out[7]); endproperty
  a_ext: assert property (p_ext) else $error("external taken while masked");
  // basic mode: channel n needs status bit n
  property p_iob;
    intr_take && intr_class == `CRI_CL_IO && !ec_mode |-> |($past(psw_out) & (16'h8000 >> intr_code[1:0]));
  endproperty
  a_iob: assert property (p_iob) else $error("channel taken while masked");
  property p_ioe; intr_take && intr_class == `CRI_CL_IO && ec_mode |-> $past(psw_out[6]); endproperty
  a_ioe: assert property (p_ioe) else $error("channel taken with summary mask off");
  c_ext: cover property (intr_take && intr_class == `CRI_CL_EXT);
  c_low: cover property (low_wr);
  c_dat: cover property (dat_enable);
endmodule // cri_unit_chk
bind cri_unit cri_unit_chk cri_unit_chk_inst (.*);

// ### sim/tb.sv
`timescale 1ns/1ns
`include "cri_defs.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  logic aclk = 1'h0, aresetn = 1'h0; // clock, reset
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, instr_reg = 4'h0; // addresses
  logic [31:0] s_axi_wdata = 32'h0, instr_data = 32'h0; // write data
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0; // write channel
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0; // read channel
  logic instr_valid = 1'h0, insn_boundary = 1'h0; // sequencer strobes
  logic [1:0] instr_op = 2'h0; // opcode
  logic [1:0] instr_ilc = 2'h1; // instruction length code
  logic [4:0] ext_req = 5'h0; // external requests
  logic [3:0] chan_req = 4'h0; // channel requests
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // bus answers
  logic instr_done, intr_take, low_wr, ec_mode, dat_enable; // status outputs
  logic [1:0] s_axi_bresp, s_axi_rresp, intr_class, intr_ilc; // codes
  logic [31:0] s_axi_rdata, instr_rdata, low_data; // data outputs
  logic [15:0] intr_code; // taken code
  logic [11:0] low_addr; // fixed store address
  logic [0:15] psw_out; // status word
  logic [31:0] rv; // last read data
  logic [1:0] rr; // last response
  int miscompares = 0, cmp_count = 0, cyc = 0;
  // mask positions and codes mirror the design defaults
  localparam int SUB[5] = '{26, 24, 21, 20, 25};
  localparam logic [15:0] CODE[5] = '{`CRI_EC_SIG, `CRI_EC_ITMR, `CRI_EC_CPUT, `CRI_EC_CKC, `CRI_EC_CONS};
  // load/store rows: register number beside the word it must hold
  localparam logic [35:0] ROWS[4] = '{{4'hF, 32'hA5C3_0F81}, {4'h7, 32'hFFFF_FFFF}, {4'h1, 32'h8000_0001},
    {4'h3, 32'h0}};
  cri_unit cri_unit_inst (.s_axi_wstrb(4'hF), .*);
  // free-running clock
  initial forever #20 aclk = ~aclk;
  // hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      results();
    end
  end
  task results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // bus write: hold each valid until its ready, wait for the response
  task automatic wr(input [3:0] a, input [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask
  // bus read
  task automatic rd(input [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask
  // one instruction pulse
  task automatic ins(input [1:0] op, input [3:0] r, input [31:0] d);
    instr_op <= op;
    instr_reg <= r;
    instr_data <= d;
    instr_valid <= 1'h1;
    @(posedge aclk);
    instr_valid <= 1'h0;
    #1 `CHK(instr_done, 1'h1)
    @(posedge aclk);
  endtask
  // boundary pulse after requests have crossed the synchroniser
  task automatic bnd(input [1:0] cl, input [15:0] cd);
    logic got;
    repeat (4) @(posedge aclk);
    insn_boundary <= 1'h1;
    @(posedge aclk);
    insn_boundary <= 1'h0;
    #1 got = intr_take;
    @(posedge aclk);
    `CHK(got, cl != `CRI_CL_NONE)
    if (got) `CHK({intr_class, intr_code}, {cl, cd})
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(`CRI_A_PSW);
    `CHK({rv, ec_mode, intr_class}, {32'h0, 1'h0, `CRI_CL_NONE})
    rd(4'hC);
    `CHK({rr, rv}, {`CRI_RESP_ERR, 32'h0})
    wr(4'hC, 32'hFFFF_FFFF);
    `CHK(rr, `CRI_RESP_ERR)
    $display("reset and map done");
    foreach (ROWS[i]) ins(`CRI_OP_LCTL, ROWS[i][35:32], ROWS[i][31:0]);
    foreach (ROWS[i]) begin
      ins(`CRI_OP_STCTL, ROWS[i][35:32], 32'h0);
      `CHK(instr_rdata, ROWS[i][31:0])
    end
    $display("load and store done");
    // each subclass: all other bits set refuses, own bit alone accepts
    wr(`CRI_A_PSW, 32'h0100);
    for (int i = 0; i < 5; i++) begin
      ins(`CRI_OP_LCTL, 4'h0, ~(32'h1 << (31 - SUB[i])));
      ext_req <= 5'h1 << i;
      bnd(`CRI_CL_NONE, 16'h0);
      ins(`CRI_OP_LCTL, 4'h0, 32'h1 << (31 - SUB[i]));
      bnd(`CRI_CL_EXT, CODE[i]);
      ext_req <= 5'h0;
    end
    wr(`CRI_A_PSW, 32'h0);
    ins(`CRI_OP_LCTL, 4'h0, 32'hFFFF_FFFF);
    ext_req <= 5'h1F;
    bnd(`CRI_CL_NONE, 16'h0);
    chan_req <= 4'h1;
    wr(`CRI_A_PSW, 32'h8100);
    ext_req <= 5'h12;
    bnd(`CRI_CL_EXT, `CRI_EC_ITMR);
    ext_req <= 5'h0;
    bnd(`CRI_CL_IO, 16'h0);
    chan_req <= 4'h2;
    bnd(`CRI_CL_NONE, 16'h0);
    chan_req <= 4'h0;
    $display("external and channel gating done");
    ins(`CRI_OP_LCTL, 4'h0, 32'h0);
    ins(`CRI_OP_SSM, 4'h0, 32'h5A);
    rd(`CRI_A_PSW);
    `CHK(rv, 32'h5A00)
    ins(`CRI_OP_LCTL, 4'h0, 32'h4000_0000);
    ins(`CRI_OP_SSM, 4'h0, 32'hFF);
    rd(`CRI_A_PSW);
    `CHK(rv, 32'h5A00)
    bnd(`CRI_CL_PROG, `CRI_PC_SPECOP);
    `CHK(intr_ilc, 2'h1)
    // problem state: no load, no store
    instr_ilc <= 2'h2;
    wr(`CRI_A_PSW, 32'h1);
    ins(`CRI_OP_LCTL, 4'hF, 32'h0);
    ins(`CRI_OP_STCTL, 4'hF, 32'h0);
    `CHK(instr_rdata, 32'h0)
    bnd(`CRI_CL_PROG, `CRI_PC_PRIV);
    `CHK(intr_ilc, 2'h2)
    wr(`CRI_A_PSW, 32'h0);
    ins(`CRI_OP_STCTL, 4'hF, 32'h0);
    `CHK(instr_rdata, ROWS[0][31:0])
    $display("privilege and set-mask done");
    // extended mode: channel masks move to register two
    ins(`CRI_OP_LCTL, 4'h2, 32'h2000_0000);
    ins(`CRI_OP_LCTL, 4'h0, 32'h80);
    wr(`CRI_A_PSW, 32'h0308);
    `CHK(ec_mode, 1'h1)
    chan_req <= 4'h6;
    bnd(`CRI_CL_IO, 16'h2);
    chan_req <= 4'h0;
    ext_req <= 5'h2;
    bnd(`CRI_CL_EXT, `CRI_EC_ITMR);
    `CHK({low_addr, low_data}, {`CRI_LOC_EXT, 16'h0000, `CRI_EC_ITMR})
    ext_req <= 5'h0;
    wr(`CRI_A_PSW, 32'h0408);
    repeat (2) @(posedge aclk);
    `CHK(dat_enable, 1'h1)
    wr(`CRI_A_CTL, 32'h1);
    rd(`CRI_A_STAT);
    `CHK(rv[22:21], 2'h1)
    wr(`CRI_A_PSW, 32'h0400);
    rd(`CRI_A_STAT);
    `CHK(rv[22:21], 2'h0)
    $display("extended mode done");
    results();
  end
endmodule // tb
